// File: hdl/pfx_defs.svh
// Offsets, field positions, opcodes, reset values and clock counts of the
// prefix and operand decoder. Assumes inclusion by its bare name only.
`ifndef PFX_DEFS_SVH
`define PFX_DEFS_SVH

// ========================================================================
// Register byte offsets on the AXI4-Lite slave.
`define PFX_REG_INSTR    8'h00
`define PFX_REG_STATUS   8'h04
`define PFX_REG_PSW      8'h08
`define PFX_REG_SAVED    8'h0C
`define PFX_REG_GPR_LO   8'h10
`define PFX_REG_GPR_HI   8'h14
`define PFX_REG_SEG      8'h18
`define PFX_REG_TVEC     8'h1C
`define PFX_REG_BR_BASE  8'h20
`define PFX_REG_BR_OFS   8'h24

// ========================================================================
// AXI response codes.
`define PFX_RESP_OKAY    2'h0
`define PFX_RESP_SLVERR  2'h2
`define PFX_RESP_DECERR  2'h3

// ========================================================================
// Opcodes. Register forms use the low three bits as the register number.
`define PFX_OP_PREFIX     8'h11
`define PFX_OP_ST_ABS_IMM 8'hCF
`define PFX_OP_LD_A_HL    8'h8B
`define PFX_OP_ST_HL_A    8'h9B
`define PFX_OP_LD_A_ABS   8'h8F
`define PFX_OP_LDW_AX_ABS 8'hAF
`define PFX_OP_PSW_IMM    8'hCE
`define PFX_OP_PSW_A      8'h9E
`define PFX_OP_A_PSW      8'h8E
`define PFX_OP_ES_IMM     8'h41
`define PFX_OP_ES_A       8'h9D
`define PFX_OP_A_ES       8'h8D
`define PFX_OP_SET_CY     8'h20
`define PFX_OP_CLR_CY     8'h21
`define PFX_OP_RESTORE    8'h22
`define PFX_OP_R_IMM      5'h0A
`define PFX_OP_A_R        5'h0C
`define PFX_OP_R_A        5'h0E

// ========================================================================
// Register numbers and status word fields.
`define PFX_R_X          3'h0
`define PFX_R_A          3'h1
`define PFX_R_L          3'h6
`define PFX_R_H          3'h7
`define PFX_PSW_IE       7
`define PFX_PSW_Z        6
`define PFX_PSW_AC       4
`define PFX_PSW_RBS_LO   2
`define PFX_PSW_CY       0
`define PFX_PSW_RESET    8'h00
`define PFX_SEG_RESET    4'hF
`define PFX_TOP_SEG      4'hF

// ========================================================================
// Address areas, table vectors and instruction clock counts.
`define PFX_PROG_AREA_END 20'hF8000
`define PFX_TVEC_BASE     16'h0080
`define PFX_CLK_BASE      3'h1
`define PFX_CLK_PROG_READ 3'h4
`define PFX_CLK_PSW_WRITE 3'h3

`endif

// File: hdl/pfx_pkg.sv
// Types of the prefix and operand decoder: states, flag modes and the
// single packed state record. Assumes pfx_defs.svh is on the include path.
`include "pfx_defs.svh"

package pfx_pkg;

  // ======================================================================
  // Decoder states and per-flag update modes.
  typedef enum logic [1:0] {PFX_IDLE, PFX_OPER, PFX_EXEC} pfx_state_t;
  typedef enum logic [2:0] {FLAG_KEEP, FLAG_CLR, FLAG_SET, FLAG_RESULT,
                            FLAG_RESTORE} pfx_flag_t;

  // ======================================================================
  // Entire state of the top module.
  typedef struct packed {
    logic             aw_got;
    logic [7:0]       awaddr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    pfx_state_t       st;
    logic             prefix;
    logic [7:0]       opcode;
    logic [23:0]      ops;
    logic [1:0]       need;
    logic [1:0]       got;
    logic [2:0]       cnt;
    logic [2:0]       last_clks;
    logic [1:0]       rd_kind;
    logic             illegal;
    logic [7:0][7:0]  gpr;
    logic [3:0]       es;
    logic [7:0]       program_status_word;
    logic [7:0]       saved;
    logic [4:0]       tvec;
    logic [19:0]      br_base;
    logic [16:0]      br_ofs;
    logic             mem_re;
    logic             mem_we;
    logic             mem_wide;
    logic [19:0]      mem_addr;
    logic [15:0]      mem_wdata;
  } pfx_regs_t;

endpackage

// File: hdl/pfx_decoder.sv
// Prefix and operand decoder core with an AXI4-Lite register slave.
// Assumes one clock, read data valid on MEM_RDATA from the very cycle of the
// read strobe until the instruction ends, and software feeding bytes.
// Operation
// - Prefixed access uses segment register upper bits
// - Prefix covers only the next instruction
// - Byte 11H recognised ahead of opcode
// - Each flag: keep, result, restore; carry also clear, set
// - Address built from upper, high, low parts
// - Accumulator, wide pair, three further pairs
// - Branch offsets are signed, short or long
// - Table vector gives even 0080H-00BFH address
// - Status word: flags, bank field, enable
// - One instruction clock is one CLK
// - Program area reads take more clocks
// - Wide accesses force address bit zero
`timescale 1ns/1ps
`default_nettype none
`include "pfx_defs.svh"

module pfx_decoder (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [19:0]      MEM_ADDR,
  output logic             MEM_RE,
  output logic             MEM_WE,
  output logic             MEM_WIDE,
  output logic [15:0]      MEM_WDATA,
  input  wire logic [15:0] MEM_RDATA,
  output logic             BUSY
);

  // ======================================================================
  // Helpers.
  function automatic logic flag_apply(input pfx_pkg::pfx_flag_t m,
    input logic cur, input logic res, input logic sav);
    unique case (m)
      pfx_pkg::FLAG_KEEP:    flag_apply = cur;
      pfx_pkg::FLAG_CLR:     flag_apply = 1'b0;
      pfx_pkg::FLAG_SET:     flag_apply = 1'b1;
      pfx_pkg::FLAG_RESULT:  flag_apply = res;
      pfx_pkg::FLAG_RESTORE: flag_apply = sav;
      default:               flag_apply = cur;
    endcase
  endfunction

  function automatic logic [1:0] oper_count(input logic [7:0] op);
    if (op == `PFX_OP_ST_ABS_IMM)
      oper_count = 2'h3;
    else if (op == `PFX_OP_LD_A_ABS || op == `PFX_OP_LDW_AX_ABS)
      oper_count = 2'h2;
    else if (op == `PFX_OP_PSW_IMM || op == `PFX_OP_ES_IMM ||
             op[7:3] == `PFX_OP_R_IMM)
      oper_count = 2'h1;
    else
      oper_count = 2'h0;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  pfx_pkg::pfx_regs_t s;
  pfx_pkg::pfx_regs_t n;
  logic [15:0] tvec_addr;
  logic [19:0] br_target;
  logic        prog_hit;

  // Table vector: index doubled keeps the address even and inside the
  // table, so no odd or out-of-range vector can ever be formed.
  assign tvec_addr = `PFX_TVEC_BASE + {10'h000, s.tvec, 1'b0};
  // Displacements sign-extend to the full address width before adding.
  assign br_target = s.br_base + (s.br_ofs[16] ?
    {{4{s.br_ofs[15]}}, s.br_ofs[15:0]} :
    {{12{s.br_ofs[7]}}, s.br_ofs[7:0]});
  assign prog_hit = s.mem_addr < `PFX_PROG_AREA_END;

  // ======================================================================
  // Next-state logic: bus slave, byte collection and execution.
  always_comb
  begin
    logic                byte_ok;
    logic [7:0]          bval;
    logic                start;
    logic [7:0]          op;
    logic [23:0]         opnd;
    logic [15:0]         a16;
    logic [3:0]          seg;
    logic [2:0]          clks;
    logic [7:0]          res;
    logic                psw_wr;
    pfx_pkg::pfx_flag_t  zm;
    pfx_pkg::pfx_flag_t  am;
    pfx_pkg::pfx_flag_t  cm;
    logic [2:0]          r;
    byte_ok = 1'b0;
    bval = s.wdata[7:0];
    start = 1'b0;
    op = s.opcode;
    opnd = s.ops;
    a16 = 16'h0000;
    seg = `PFX_TOP_SEG;
    clks = `PFX_CLK_BASE;
    res = 8'h00;
    psw_wr = 1'b0;
    zm = pfx_pkg::FLAG_KEEP;
    am = pfx_pkg::FLAG_KEEP;
    cm = pfx_pkg::FLAG_KEEP;
    r = 3'h0;
    n = s;
    n.mem_re = 1'b0;
    n.mem_we = 1'b0;

    // Read channel: one read at a time, answered the cycle after ARVALID.
    if (s.rvalid && RREADY)
      n.rvalid = 1'b0;
    if (ARVALID && !s.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rresp = `PFX_RESP_OKAY;
      unique case (ARADDR[7:0])
        `PFX_REG_INSTR:   n.rdata = {24'h000000, s.opcode};
        `PFX_REG_STATUS:  n.rdata = {21'h000000, s.last_clks, 4'h0,
                                     s.illegal, s.prefix,
                                     s.st == pfx_pkg::PFX_EXEC, 1'b0};
        `PFX_REG_PSW:     n.rdata = {24'h000000, s.program_status_word};
        `PFX_REG_SAVED:   n.rdata = {24'h000000, s.saved};
        `PFX_REG_GPR_LO:  n.rdata = s.gpr[3:0];
        `PFX_REG_GPR_HI:  n.rdata = s.gpr[7:4];
        `PFX_REG_SEG:     n.rdata = {28'h0000000, s.es};
        `PFX_REG_TVEC:    n.rdata = {16'h0000, tvec_addr};
        `PFX_REG_BR_BASE: n.rdata = {12'h000, s.br_base};
        `PFX_REG_BR_OFS:  n.rdata = {12'h000, br_target};
        default:
        begin
          n.rdata = 32'h00000000;
          n.rresp = `PFX_RESP_DECERR;
        end
      endcase
    end

    // Write channel: address and data latched in either order.
    if (s.bvalid && BREADY)
      n.bvalid = 1'b0;
    if (AWVALID && !s.aw_got && !s.bvalid)
    begin
      n.aw_got = 1'b1;
      n.awaddr = AWADDR[7:0];
    end
    if (WVALID && !s.w_got && !s.bvalid)
    begin
      n.w_got = 1'b1;
      n.wdata = WDATA;
      n.wstrb = WSTRB;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `PFX_RESP_OKAY;
      unique case (s.awaddr)
        `PFX_REG_INSTR:
          if (s.wstrb[0] && s.st != pfx_pkg::PFX_EXEC)
            byte_ok = 1'b1;
          else
            n.bresp = `PFX_RESP_SLVERR;
        `PFX_REG_SAVED:
          n.saved = 8'(merge({24'h000000, s.saved}, s.wdata, s.wstrb));
        `PFX_REG_TVEC:
          n.tvec = 5'(merge({27'h0000000, s.tvec}, s.wdata, s.wstrb));
        `PFX_REG_BR_BASE:
          n.br_base = 20'(merge({12'h000, s.br_base}, s.wdata, s.wstrb));
        `PFX_REG_BR_OFS:
          n.br_ofs = 17'(merge({15'h0000, s.br_ofs}, s.wdata, s.wstrb));
        `PFX_REG_STATUS, `PFX_REG_PSW, `PFX_REG_GPR_LO, `PFX_REG_GPR_HI,
        `PFX_REG_SEG: ;
        default: n.bresp = `PFX_RESP_DECERR;
      endcase
    end

    // Byte collection: the prefix byte is caught before any opcode.
    unique case (s.st)
      pfx_pkg::PFX_IDLE:
        if (byte_ok && bval == `PFX_OP_PREFIX)
          n.prefix = 1'b1;
        else if (byte_ok)
        begin
          op = bval;
          n.opcode = bval;
          n.got = 2'h0;
          n.need = oper_count(bval);
          if (oper_count(bval) == 2'h0)
            start = 1'b1;
          else
            n.st = pfx_pkg::PFX_OPER;
        end
      pfx_pkg::PFX_OPER:
        if (byte_ok)
        begin
          opnd[8*s.got +: 8] = bval;
          n.ops = opnd;
          n.got = s.got + 2'h1;
          start = (s.got + 2'h1) == s.need;
        end
      pfx_pkg::PFX_EXEC:
        if (s.cnt == 3'h0)
        begin
          if (s.rd_kind == 2'h1)
            n.gpr[`PFX_R_A] = MEM_RDATA[7:0];
          else if (s.rd_kind == 2'h2)
            {n.gpr[`PFX_R_A], n.gpr[`PFX_R_X]} = MEM_RDATA;
          n.rd_kind = 2'h0;
          n.prefix = 1'b0;
          n.st = pfx_pkg::PFX_IDLE;
        end
        else
          n.cnt = s.cnt - 3'h1;
    endcase

    // Execution start: effects on registers and the memory strobes.
    if (start)
    begin
      // The segment register is trusted to have been loaded already.
      if (s.prefix)
        seg = s.es;
      n.illegal = 1'b0;
      n.mem_wide = 1'b0;
      r = op[2:0];
      if (op == `PFX_OP_ST_ABS_IMM)
      begin
        a16 = opnd[15:0];
        n.mem_we = 1'b1;
        n.mem_wdata = {8'h00, opnd[23:16]};
      end
      else if (op == `PFX_OP_LD_A_HL || op == `PFX_OP_ST_HL_A)
      begin
        a16 = {s.gpr[`PFX_R_H], s.gpr[`PFX_R_L]};
        n.mem_re = op == `PFX_OP_LD_A_HL;
        n.mem_we = op == `PFX_OP_ST_HL_A;
        n.mem_wdata = {8'h00, s.gpr[`PFX_R_A]};
        n.rd_kind = {1'b0, op == `PFX_OP_LD_A_HL};
      end
      else if (op == `PFX_OP_LD_A_ABS || op == `PFX_OP_LDW_AX_ABS)
      begin
        n.mem_re = 1'b1;
        n.mem_wide = op == `PFX_OP_LDW_AX_ABS;
        // Odd word addresses are rounded down rather than split in two.
        a16 = {opnd[15:1], opnd[0] & (op == `PFX_OP_LD_A_ABS)};
        n.rd_kind = (op == `PFX_OP_LD_A_ABS) ? 2'h1 : 2'h2;
      end
      else if (op == `PFX_OP_PSW_IMM || op == `PFX_OP_PSW_A)
      begin
        res = (op == `PFX_OP_PSW_IMM) ? opnd[7:0] : s.gpr[`PFX_R_A];
        psw_wr = 1'b1;
        clks = `PFX_CLK_PSW_WRITE;
        zm = pfx_pkg::FLAG_RESULT;
        am = pfx_pkg::FLAG_RESULT;
        cm = pfx_pkg::FLAG_RESULT;
      end
      else if (op == `PFX_OP_A_PSW)
        n.gpr[`PFX_R_A] = s.program_status_word;
      else if (op == `PFX_OP_ES_IMM)
        n.es = opnd[3:0];
      else if (op == `PFX_OP_ES_A)
        n.es = s.gpr[`PFX_R_A][3:0];
      else if (op == `PFX_OP_A_ES)
        n.gpr[`PFX_R_A] = {4'h0, s.es};
      else if (op == `PFX_OP_SET_CY)
        cm = pfx_pkg::FLAG_SET;
      else if (op == `PFX_OP_CLR_CY)
        cm = pfx_pkg::FLAG_CLR;
      else if (op == `PFX_OP_RESTORE)
      begin
        zm = pfx_pkg::FLAG_RESTORE;
        am = pfx_pkg::FLAG_RESTORE;
        cm = pfx_pkg::FLAG_RESTORE;
      end
      else if (op[7:3] == `PFX_OP_R_IMM)
        n.gpr[r] = opnd[7:0];
      else if (op[7:3] == `PFX_OP_A_R)
        n.gpr[`PFX_R_A] = s.gpr[r];
      else if (op[7:3] == `PFX_OP_R_A && r != `PFX_R_A)
        n.gpr[r] = s.gpr[`PFX_R_A];
      else
        n.illegal = 1'b1;
      // Whole status word: bank field and enable come with the flags.
      if (psw_wr)
        n.program_status_word = res;
      n.program_status_word[`PFX_PSW_Z] = flag_apply(zm, s.program_status_word[`PFX_PSW_Z],
        res[`PFX_PSW_Z], s.saved[`PFX_PSW_Z]);
      n.program_status_word[`PFX_PSW_AC] = flag_apply(am, s.program_status_word[`PFX_PSW_AC],
        res[`PFX_PSW_AC], s.saved[`PFX_PSW_AC]);
      n.program_status_word[`PFX_PSW_CY] = flag_apply(cm, s.program_status_word[`PFX_PSW_CY],
        res[`PFX_PSW_CY], s.saved[`PFX_PSW_CY]);
      n.mem_addr = {seg, a16[15:8], a16[7:0]};
      if (n.mem_re && {seg, a16} < `PFX_PROG_AREA_END)
        clks = `PFX_CLK_PROG_READ;
      clks = clks + {2'h0, s.prefix};
      n.last_clks = clks;
      n.cnt = clks - 3'h1;
      n.st = pfx_pkg::PFX_EXEC;
    end
  end

  // ======================================================================
  // State register.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s <= '0;
      s.st <= pfx_pkg::PFX_IDLE;
      s.program_status_word <= `PFX_PSW_RESET;
      s.es <= `PFX_SEG_RESET;
    end
    else
      s <= n;
  end

  // Handshakes are combinational; data come straight from the record.
  assign AWREADY = !s.aw_got && !s.bvalid;
  assign WREADY = !s.w_got && !s.bvalid;
  assign ARREADY = !s.rvalid;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign RVALID = s.rvalid;
  assign RRESP = s.rresp;
  assign RDATA = s.rdata;
  assign MEM_ADDR = s.mem_addr;
  assign MEM_RE = s.mem_re;
  assign MEM_WE = s.mem_we;
  assign MEM_WIDE = s.mem_wide;
  assign MEM_WDATA = s.mem_wdata;
  assign BUSY = s.st == pfx_pkg::PFX_EXEC;

  // ======================================================================
  // Checks on the decoder.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  prefix_once_a: assert property (s.st == pfx_pkg::PFX_EXEC &&
    s.cnt == 3'h0 |=> !s.prefix) else $error("prefix outlived instr");
  seg_addr_a: assert property ((MEM_RE || MEM_WE) && s.prefix
    |-> MEM_ADDR[19:16] == s.es) else $error("segment not applied");
  top_window_a: assert property ((MEM_RE || MEM_WE) && !s.prefix
    |-> MEM_ADDR[19:16] == 4'hF) else $error("plain access left top");
  prefix_seen_a: assert property (s.st == pfx_pkg::PFX_IDLE &&
    s.aw_got && s.w_got && !s.bvalid && s.awaddr == `PFX_REG_INSTR &&
    s.wstrb[0] && s.wdata[7:0] == 8'h11 |=> s.prefix)
    else $error("prefix byte missed");
  wide_even_a: assert property (MEM_WIDE |-> !MEM_ADDR[0])
    else $error("odd wide address");
  tvec_range_a: assert property (tvec_addr >= 16'h0080 &&
    tvec_addr <= 16'h00BF && !tvec_addr[0]) else $error("bad vector");
  slow_read_a: assert property (MEM_RE && prog_hit && !s.prefix
    |-> BUSY [*4] ##1 !BUSY) else $error("program read not 4 clocks");
  fast_read_a: assert property (MEM_RE && !prog_hit && !s.prefix
    |-> ##1 !BUSY) else $error("ram read not 1 clock");
  move_flags_a: assert property (s.st == pfx_pkg::PFX_IDLE &&
    n.st == pfx_pkg::PFX_EXEC && n.opcode[7:3] == 5'h0C
    |=> $stable(s.program_status_word)) else $error("move touched flags");
  psw_load_a: assert property (MEM_RE == 1'b0 && s.st ==
    pfx_pkg::PFX_OPER && n.st == pfx_pkg::PFX_EXEC &&
    s.opcode == 8'hCE |=> s.program_status_word == $past(n.ops[7:0]))
    else $error("status word load wrong");
  short_sign_a: assert property (!s.br_ofs[16] && s.br_ofs[7]
    |-> br_target == s.br_base - {12'h000, 8'h00 - s.br_ofs[7:0]})
    else $error("short offset not signed");

  prefixed_read_c: cover property (MEM_RE && s.prefix);
  program_read_c: cover property (MEM_RE && prog_hit);
  psw_write_c: cover property (s.opcode == 8'h9E && BUSY);
  refused_byte_c: cover property (BVALID && BRESP == 2'h2);

endmodule
`default_nettype wire

// File: testbench/pfx_mem_model.sv
// Behavioural data memory on the far side of the decoder's memory port.
// Assumes the decoder wants read data from its read strobe cycle until
// BUSY falls, and that writes need no answer.
`timescale 1ns/1ps
`default_nettype none

module pfx_mem_model (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [19:0] MEM_ADDR,
  input  wire logic        MEM_RE,
  input  wire logic        BUSY,
  output logic      [15:0] MEM_RDATA
);
  logic [15:0] word;
  logic        valid;

  // ======================================================================
  // Read data
  // Data is a pattern of the address so the bench can predict it. Outside
  // the hold window the inverse is shown, so a capture more than one clock late cannot pass.
  assign word = {MEM_ADDR[7:0] ^ 8'hC3, MEM_ADDR[7:0] ^ 8'h3C};

  // A one-clock read is captured at the end of the strobe cycle itself,
  // so the data must already stand while the strobe is high.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      valid <= 1'b0;
    else if (MEM_RE)
      valid <= 1'b1;
    else if (!BUSY)
      valid <= 1'b0;
  end

  assign MEM_RDATA = (MEM_RE || valid) ? word : ~word;
endmodule

`default_nettype wire

// File: testbench/cpu_prefix_and_operand_decode_tb.sv
// Self-checking bench: instruction bytes and register reads over AXI4-Lite.
// Assumes pfx_defs.svh on the include path and the memory model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "pfx_defs.svh"

module cpu_prefix_and_operand_decode_tb;
  logic        clk;
  logic        rst;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic        mem_re, mem_we, mem_wide;
  logic [1:0]  bresp, rresp, rs;
  logic [19:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [31:0] o;
  logic [31:0] o_tab [4] = '{32'h00080, 32'h10080, 32'h0007F, 32'h1FF00};
  int          n_we = 0;
  int          fail_count;
  int          n_tests;

  // ======================================================================
  // Clock and instances
  always #4 clk = ~clk;

  // Write strobes are one-cycle pulses, so they are counted as they pass.
  always @(posedge clk)
    if (mem_we === 1'b1)
      n_we++;

  pfx_decoder i_pfx_decoder (
    .CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .MEM_ADDR(mem_addr),
    .MEM_RE(mem_re), .MEM_WE(mem_we), .MEM_WIDE(mem_wide),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .BUSY(busy));

  pfx_mem_model i_pfx_mem_model (
    .CLK(clk), .RST(rst), .MEM_ADDR(mem_addr), .MEM_RE(mem_re),
    .BUSY(busy), .MEM_RDATA(mem_rdata));

  // ======================================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address and data are offered together and each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Bounded wait of 20 cycles; a decoder that never finishes fails the byte response check.
  task automatic idle();
    @(posedge clk);
    for (int n = 0; n < 20 && busy !== 1'b0; n++)
      @(posedge clk);
  endtask

  task automatic exec(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      idle();
      wr(`PFX_REG_INSTR, {24'h0, q[i]}, 4'h1);
      check("byte resp", 32'(rs), 32'(`PFX_RESP_OKAY));
    end
    idle();
  endtask

  task automatic clks(input logic [2:0] n);
    rd_reg(`PFX_REG_STATUS);
    check("clocks", 32'(rd[10:8]), 32'(n));
  endtask

  task automatic give_verdict();
    $display("TB: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ======================================================================
  // Main sequence
  initial
  begin
    {clk, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'h0;
    fail_count = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`PFX_REG_PSW);
    check("psw reset", rd, 32'(`PFX_PSW_RESET));
    exec('{`PFX_OP_ES_IMM, 8'h03});
    exec('{`PFX_OP_PREFIX, `PFX_OP_ST_ABS_IMM, 8'h34, 8'h12, 8'h5A});
    check("seg store", 32'(mem_addr), 32'h31234);
    check("store data", 32'(mem_wdata[7:0]), 32'h5A);
    clks(3'h2);
    exec('{`PFX_OP_ST_ABS_IMM, 8'h35, 8'h12, 8'hA5});
    check("plain store", 32'(mem_addr), 32'hF1235);
    clks(3'h1);
    check("write strobes", 32'(n_we), 32'h2);
    exec('{8'h57, 8'h12, 8'h56, 8'h34, `PFX_OP_PREFIX, `PFX_OP_LD_A_HL});
    check("seg load", 32'(mem_addr), 32'h31234);
    clks(3'h5);
    rd_reg(`PFX_REG_GPR_LO);
    check("acc", 32'(rd[15:8]), 32'(8'h34 ^ 8'h3C));
    // High data area: short read.
    exec('{8'h57, 8'hFE, 8'h56, 8'h40, `PFX_OP_LD_A_HL});
    check("top load", 32'(mem_addr), 32'hFFE40);
    clks(3'h1);
    rd_reg(`PFX_REG_GPR_LO);
    check("fast acc", 32'(rd[15:8]), 32'(8'h40 ^ 8'h3C));
    // Odd word address loses bit zero.
    exec('{`PFX_OP_LDW_AX_ABS, 8'h57, 8'h12});
    check("word addr", 32'(mem_addr), 32'hF1256);
    check("word wide", 32'(mem_wide), 32'h1);
    clks(3'h4);
    rd_reg(`PFX_REG_GPR_LO);
    check("pair", 32'(rd[15:0]), 32'h956A);
    // Flag modes: result, keep, clear, restore, set.
    exec('{`PFX_OP_PSW_IMM, 8'hFF});
    clks(3'h3);
    rd_reg(`PFX_REG_PSW);
    check("psw write", rd, 32'hFF);
    exec('{8'h50, 8'h00, `PFX_OP_CLR_CY});
    rd_reg(`PFX_REG_PSW);
    check("psw clear", rd, 32'hFE);
    wr(`PFX_REG_SAVED, 32'h0, 4'hF);
    exec('{`PFX_OP_RESTORE});
    rd_reg(`PFX_REG_PSW);
    check("psw restore", rd, 32'hAE);
    exec('{`PFX_OP_SET_CY});
    rd_reg(`PFX_REG_PSW);
    check("psw set", rd, 32'hAF);
    // Table vectors at both ends of the range.
    for (int i = 0; i < 32; i += 31)
    begin
      wr(`PFX_REG_TVEC, 32'(i), 4'hF);
      rd_reg(`PFX_REG_TVEC);
      check("vector", rd, 32'h80 + 32'(2 * i));
    end
    // Short and long offsets, each sign.
    wr(`PFX_REG_BR_BASE, 32'h12345, 4'hF);
    foreach (o_tab[k])
    begin
      o = o_tab[k];
      wr(`PFX_REG_BR_OFS, o, 4'hF);
      rd_reg(`PFX_REG_BR_OFS);
      check("branch", rd, 32'h12345 + (o[16] ? {{16{o[15]}}, o[15:0]} :
            {{24{o[7]}}, o[7:0]}) & 32'hFFFFF);
    end
    // Store through the pair, segment from the accumulator, refused code.
    exec('{8'h51, 8'h42, `PFX_OP_ST_HL_A});
    check("hl store", 32'(mem_addr), 32'hFFE40);
    check("hl data", 32'(mem_wdata), 32'h42);
    check("hl strobe", 32'(n_we), 32'h3);
    exec('{`PFX_OP_ES_A, 8'h71});
    rd_reg(`PFX_REG_SEG);
    check("seg from acc", rd, 32'h2);
    rd_reg(`PFX_REG_STATUS);
    check("illegal", 32'(rd[3]), 32'h1);
    rd_reg(8'h30);
    check("unmapped", 32'(rs), 32'(`PFX_RESP_DECERR));
    wr(`PFX_REG_INSTR, 32'h11, 4'h0);
    check("no strobe", 32'(rs), 32'(`PFX_RESP_SLVERR));
    give_verdict();
  end

  // Watchdog sized well beyond the few hundred cycles the run needs.
  initial
  begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
